/* File: inc/prtc_pkg.sv */
// Package for the PHY reset and test stimulus control register bank
package prtc_pkg;
   // ==========================================================
   // Register map: each index is a word number, the byte address is four times it
   localparam logic [5:0] PRTC_IDX_PHY_GENERAL_CONTROL = 6'h1f;
   localparam logic [5:0] PRTC_IDX_TEST_CTRL = 6'h25;
   localparam logic [5:0] PRTC_IDX_STRAP = 6'h30;
   localparam int PRTC_ADDR_W = 8;
   localparam logic [7:0] PRTC_ADDR_PHY_GENERAL_CONTROL = {PRTC_IDX_PHY_GENERAL_CONTROL, 2'b00};
   localparam logic [7:0] PRTC_ADDR_TEST_CTRL = {PRTC_IDX_TEST_CTRL, 2'b00};
   localparam logic [7:0] PRTC_ADDR_STRAP = {PRTC_IDX_STRAP, 2'b00};
   // ==========================================================
   // Reset values
   localparam logic [15:0] PRTC_PHY_GENERAL_CONTROL_RST = 16'h0000;
   localparam logic [15:0] PRTC_TEST_CTRL_RST = 16'h0480;
   // ==========================================================
   // Field positions
   localparam int PRTC_B_SOFT_RESET = 15;
   localparam int PRTC_B_SOFT_RESTART = 14;
   localparam int PRTC_F_PULSE_HI = 11;
   localparam int PRTC_F_PULSE_LO = 10;
   localparam int PRTC_B_ZC_HIGH = 9;
   localparam int PRTC_B_FE_EN = 8;
   localparam int PRTC_B_ALL_CH = 7;
   localparam int PRTC_F_CH_HI = 6;
   localparam int PRTC_F_CH_LO = 5;
   localparam int PRTC_B_TEN_EN = 4;
   localparam int PRTC_F_PAT_HI = 3;
   localparam logic [15:0] PRTC_TEST_CTRL_MASK = 16'h0fff;
   localparam logic [15:0] PRTC_PHY_GENERAL_CONTROL_MASK = 16'hc000;
   // ==========================================================
   // Timing
   localparam int PRTC_CLK_MHZ = 250;
   localparam int PRTC_RESET_NS = 40;
   localparam int PRTC_RESET_CYC = (PRTC_RESET_NS * PRTC_CLK_MHZ + 999) / 1000;
   localparam logic [1:0] PRTC_PULSE_P2 = 2'h0;
   localparam logic [1:0] PRTC_PULSE_M2 = 2'h1;
   localparam logic [1:0] PRTC_PULSE_P1 = 2'h2;
   localparam logic [1:0] PRTC_PULSE_M1 = 2'h3;
   typedef enum logic [1:0] {
      PRTC_IDLE = 2'b00,
      PRTC_RESET = 2'b01,
      PRTC_RESTART = 2'b10
   } prtc_state_e;
endpackage : prtc_pkg

/* File: sim/prtc_top_chk.sv */
// Port checker for the reset and test stimulus register bank
`timescale 1ns/1ps
module prtc_top_chk
   import prtc_pkg::*;
#(
   parameter int RESET_CYC = PRTC_RESET_CYC
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [prtc_pkg::PRTC_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [31:0] o_prdata,
   input wire logic o_phy_reset,
   input wire logic o_phy_restart,
   input wire logic [3:0] o_channel_enable,
   input wire logic o_symbol_valid,
   input wire logic o_symbol_one
);
   // =====
   // Helpers
   logic wr_gen;
   int unsigned hold_cnt;
   // Writes landing during a hold are ignored, so only idle writes count
   assign wr_gen = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[1]
      && i_paddr == PRTC_ADDR_PHY_GENERAL_CONTROL && !o_phy_reset && !o_phy_restart;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= o_phy_reset ? hold_cnt + 1 : 0;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // =====
   // Properties
   property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
   property p_pulse; o_pready |=> !o_pready; endproperty
   property p_upper; o_pready |-> !o_pslverr && o_prdata[31:16] == 16'h0; endproperty
   property p_soft; wr_gen && i_pwdata[15] |=> ##[0:1] o_phy_reset; endproperty
   property p_rst; wr_gen && i_pwdata[14] && !i_pwdata[15] |=> ##[0:1] o_phy_restart;
   endproperty
   property p_len; $fell(o_phy_reset) |-> hold_cnt == RESET_CYC; endproperty
   property p_ptn; o_symbol_valid && o_symbol_one |=> !o_symbol_one; endproperty
   property p_quiet; o_phy_reset [*2] |-> !o_symbol_valid; endproperty
   property p_chan; $onehot0(o_channel_enable) || o_channel_enable == 4'hf; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready in access");
   a_pulse: assert property (p_pulse) else $error("ready too long");
   a_upper: assert property (p_upper) else $error("bad upper data");
   a_soft: assert property (p_soft) else $error("no soft reset");
   a_rst: assert property (p_rst) else $error("no restart");
   a_len: assert property (p_len) else $error("hold length");
   a_ptn: assert property (p_ptn) else $error("two ones");
   a_quiet: assert property (p_quiet) else $error("pattern in hold");
   a_chan: assert property (p_chan) else $error("channel mix");
   c_soft: cover property ($rose(o_phy_reset));
   c_rst: cover property ($rose(o_phy_restart));
   c_sym: cover property (o_symbol_valid && o_symbol_one);
endmodule : prtc_top_chk
bind prtc_top prtc_top_chk #(.RESET_CYC(RESET_CYC)) u_chk (.i_mclk, .i_sys_rst, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr, .o_prdata,
   .o_phy_reset, .o_phy_restart, .o_channel_enable, .o_symbol_valid, .o_symbol_one);

/* File: sim/testbench.sv */
// Self-checking bench for the reset and test stimulus register bank
`timescale 1ns/1ps
module testbench;
   import prtc_pkg::*;
   typedef struct packed {logic [15:0] wr; logic [15:0] rb; logic [10:0] outs;} prtc_row_s;
   localparam int HOLD = 6;
   localparam logic [7:0] TC = PRTC_ADDR_TEST_CTRL;
   localparam logic [7:0] GC = PRTC_ADDR_PHY_GENERAL_CONTROL;
   logic i_mclk, i_sys_rst, i_psel, i_penable, i_pwrite;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [3:0] i_pstrb, o_channel_enable, o_ten_pattern;
   logic [15:0] i_strap_test_ctrl;
   logic o_pready, o_pslverr, o_phy_reset, o_phy_restart, o_ten_test_enable;
   logic o_symbol_valid, o_symbol_one;
   logic [1:0] o_pulse_level_select;
   int mismatches, check_count;
   // Outputs packed as level, channels, 10M enable, 10M pattern
   prtc_row_s rows [5] = '{'{16'hf080, 16'h0080, 11'h1e0}, '{16'h0400, 16'h0400, 11'h220},
      '{16'h0820, 16'h0820, 11'h440}, '{16'h0c40, 16'h0c40, 11'h680},
      '{16'h0075, 16'h0075, 11'h115}};
   prtc_top #(.RESET_CYC(HOLD)) u_dut (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .i_pstrb, .i_strap_test_ctrl, .o_pready, .o_pslverr, .o_prdata,
      .o_phy_reset, .o_phy_restart, .o_pulse_level_select, .o_channel_enable,
      .o_ten_test_enable, .o_ten_pattern, .o_symbol_valid, .o_symbol_one);
   // =====
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Waits for ready as long as it takes; only the watchdog ends a hung access
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // Counts cycles from one leading one to the next
   task automatic per(input int e);
      int k;
      k = 0;
      while (!(o_symbol_valid === 1'b1 && o_symbol_one === 1'b1) && k < 100) begin
         @(posedge i_mclk);
         k++;
      end
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (!(o_symbol_valid === 1'b1 && o_symbol_one === 1'b1) && k < 100);
      chk(k, e);
   endtask : per
   task automatic idle_wait;
      int k;
      k = 0;
      while ((o_phy_reset !== 1'b0 || o_phy_restart !== 1'b0) && k < 40) begin
         @(posedge i_mclk);
         k++;
      end
      // A hold that never ends counts against the run
      if (o_phy_reset !== 1'b0 || o_phy_restart !== 1'b0) mismatches++;
   endtask : idle_wait
   task automatic tally_and_finish;
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // =====
   // Stimulus
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   initial begin
      #80000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {i_sys_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {4'h9, 40'h0};
      i_pstrb = 4'hf;
      i_strap_test_ctrl = 16'hfa95;
      repeat (3) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, TC, {16'hffff, rows[i].wr});
         rdc(TC, {16'h0, rows[i].rb});
         chk({o_pulse_level_select, o_channel_enable, o_ten_test_enable, o_ten_pattern},
            rows[i].outs);
      end
      // Second hard reset in mid-run: defaults return and straps are latched again
      @(posedge i_mclk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      chk(o_pulse_level_select, 32'h1);
      chk(o_symbol_valid, 32'h0);
      i_sys_rst <= 1'b0;
      rdc(TC, 32'h0480);
      rdc(PRTC_ADDR_STRAP, 32'h0a95);
      // Speed forcing sits at index 0, outside this bank, so it must not alias here
      apb(1'b1, 8'h00, 32'hffff);
      rdc(8'h00, 32'h0);
      apb(1'b1, GC, 32'h3fff);
      rdc(GC, 32'h0);
      apb(1'b1, TC, 32'h0);
      apb(1'b1, TC, 32'h0101);
      per(2);
      apb(1'b1, TC, 32'h0);
      apb(1'b1, TC, 32'h030f);
      per(32);
      apb(1'b1, TC, 32'h0);
      apb(1'b1, TC, 32'h0100);
      repeat (4) @(posedge i_mclk);
      chk(o_symbol_valid, 1'b0);
      apb(1'b1, TC, 32'h0);
      apb(1'b1, TC, 32'h0005);
      repeat (4) @(posedge i_mclk);
      chk(o_symbol_valid, 1'b0);
      apb(1'b1, TC, 32'h0855);
      apb(1'b1, GC, 32'h4000);
      rdc(GC, 32'h4000);
      idle_wait();
      rdc(GC, 32'h0);
      rdc(TC, 32'h0855);
      // Pattern running when the soft reset lands, so the hold must silence it
      apb(1'b1, TC, 32'h0);
      apb(1'b1, TC, 32'h0101);
      apb(1'b1, GC, 32'h8000);
      rdc(GC, 32'h8000);
      idle_wait();
      rdc(GC, 32'h0);
      rdc(TC, 32'h0a95);
      chk(o_symbol_valid, 32'h0);
      tally_and_finish();
   end
endmodule : testbench

/* File: verilog/prtc_pattern_gen.sv */
// One-then-N-zeros stimulus generator for the 100 Mb/s pulse pattern test
`timescale 1ns/1ps
module prtc_pattern_gen #(
   parameter int CNT_W = 5
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_run,
   input wire logic [CNT_W-1:0] i_zero_count,
   output logic o_symbol_valid,
   output logic o_symbol_one
);
   logic [CNT_W-1:0] gap;
   // ==========================================================
   // Sequencer
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         gap <= '0;
         o_symbol_valid <= 1'b0;
         o_symbol_one <= 1'b0;
      end else if (!i_run || i_zero_count == '0) begin
         // Zero count of zero empties the shifter rather than running
         gap <= '0; // [R6] [R7]
         o_symbol_valid <= 1'b0;
         o_symbol_one <= 1'b0;
      end else begin
         o_symbol_valid <= 1'b1;
         if (gap == '0) begin
            o_symbol_one <= 1'b1; // [R5]
            gap <= i_zero_count;
         end else begin
            o_symbol_one <= 1'b0;
            gap <= gap - 1'b1;
         end
      end
   end
endmodule : prtc_pattern_gen

/* File: verilog/prtc_top.sv */
// APB register bank for PHY soft reset/restart and test stimulus control
//
// Functional notes
// [R1] Writing one to the soft reset bit resets the PHY and returns all registers to default.
// [R2] On soft reset, strap-sourced register fields reload from the last latched strap value.
// [R3] Writing one to the soft restart bit restarts the PHY but leaves registers unchanged.
// [R4] Bits 11-10 select pulse level: 0 +2, 1 -2, 2 +1, 3 -1, reset value 1.
// [R5] Extended fast test sends a one then N zeros, N from bit 9 and bits 3:0, 1 to 31.
// [R6] A zero count of zero clears the pattern shifter instead of generating a sequence.
// [R7] Bit 8 enables the extended fast pattern; when clear no pattern, reset value 0.
// [R8] Software keeps bit 4 clear when using the fast test mode.
// [R9] Software writes zero before programming a new fast test setting.
// [R10] Software forces 100 Mb/s speed through the basic control register for testing.
// [R11] Soft reset and restart bits clear themselves once the action completes.
// [R12] Reserved bits read zero and ignore writes.
// [R13] Bit 4 enables 10BASE-T test modes, bits 3:0 pick its pattern and low zero count.
// [R14] Bits 7-5 route stimulus: bit 7 all channels, else 6:5 pick A, B, C or D.
`timescale 1ns/1ps
module prtc_top
   import prtc_pkg::*;
#(
   parameter int RESET_CYC = PRTC_RESET_CYC
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [prtc_pkg::PRTC_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [15:0] i_strap_test_ctrl,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   output logic o_phy_reset,
   output logic o_phy_restart,
   output logic [1:0] o_pulse_level_select,
   output logic [3:0] o_channel_enable,
   output logic o_ten_test_enable,
   output logic [3:0] o_ten_pattern,
   output logic o_symbol_valid,
   output logic o_symbol_one
);
   import prtc_pkg::*;
   // ==========================================================
   // Declarations
   logic [15:0] test_stimulus_control;
   logic [15:0] strap_latch;
   logic strap_taken;
   prtc_state_e state;
   logic [15:0] hold_cnt;
   logic wr_acc;
   logic rd_acc;
   logic soft_full_reset;
   logic soft_restart_keep_regs;
   logic fast_ethernet_pattern_enable;
   logic [4:0] zero_count;
   logic [3:0] next_channel_enable;
   logic [15:0] wdata16;
   assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
   assign rd_acc = i_psel && i_penable && !i_pwrite && o_pready;
   assign wdata16 = i_pwdata[15:0];
   assign soft_full_reset = (state == PRTC_RESET);
   assign soft_restart_keep_regs = (state == PRTC_RESTART);
   assign fast_ethernet_pattern_enable = test_stimulus_control[PRTC_B_FE_EN];
   assign zero_count = {test_stimulus_control[PRTC_B_ZC_HIGH],
                        test_stimulus_control[PRTC_F_PAT_HI:0]};
   // ==========================================================
   // Strap capture after release of the hard reset
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         strap_taken <= 1'b0;
         strap_latch <= PRTC_TEST_CTRL_RST;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap_latch <= i_strap_test_ctrl & PRTC_TEST_CTRL_MASK;
      end
   end
   // ==========================================================
   // Reset/restart sequencer
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= PRTC_IDLE;
         hold_cnt <= '0;
      end else begin
         unique case (state)
            PRTC_IDLE: begin
               if (wr_acc && i_paddr == PRTC_ADDR_PHY_GENERAL_CONTROL && i_pstrb[1]) begin
                  // Full reset wins if both bits are written together
                  if (wdata16[PRTC_B_SOFT_RESET]) begin
                     state <= PRTC_RESET; // [R1]
                     hold_cnt <= 16'(RESET_CYC);
                  end else if (wdata16[PRTC_B_SOFT_RESTART]) begin
                     state <= PRTC_RESTART; // [R3]
                     hold_cnt <= 16'(RESET_CYC);
                  end
               end
            end
            PRTC_RESET, PRTC_RESTART: begin
               if (hold_cnt <= 16'h0001) begin
                  state <= PRTC_IDLE; // [R11]
                  hold_cnt <= '0;
               end else begin
                  hold_cnt <= hold_cnt - 16'h0001;
               end
            end
            default: begin
               state <= PRTC_IDLE;
               hold_cnt <= '0;
            end
         endcase
      end
   end
   // ==========================================================
   // Test stimulus control register
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         test_stimulus_control <= PRTC_TEST_CTRL_RST; // [R4] [R7]
      end else if (soft_full_reset) begin
         test_stimulus_control <= strap_latch; // [R1] [R2]
      end else if (wr_acc && i_paddr == PRTC_ADDR_TEST_CTRL) begin
         if (i_pstrb[0]) begin
            test_stimulus_control[7:0] <= wdata16[7:0]; // [R13] [R14]
         end
         if (i_pstrb[1]) begin
            // Upper reserved nibble stays zero
            test_stimulus_control[15:8] <= wdata16[15:8] & PRTC_TEST_CTRL_MASK[15:8]; // [R12]
         end
      end
   end
   // ==========================================================
   // APB slave: zero wait states, unmapped read zero without error
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
               PRTC_ADDR_PHY_GENERAL_CONTROL: o_prdata <= {16'h0000,
                  {soft_full_reset, soft_restart_keep_regs, 14'h0000}
                  & PRTC_PHY_GENERAL_CONTROL_MASK}; // [R11] [R12]
               PRTC_ADDR_TEST_CTRL: o_prdata <= {16'h0000, test_stimulus_control};
               PRTC_ADDR_STRAP: o_prdata <= {16'h0000, strap_latch};
               default: o_prdata <= '0;
            endcase
         end else if (rd_acc) begin
            o_prdata <= o_prdata;
         end
      end
   end
   // ==========================================================
   // Channel routing
   always_comb begin
      if (test_stimulus_control[PRTC_B_ALL_CH]) begin
         next_channel_enable = 4'hf; // [R14]
      end else begin
         next_channel_enable = 4'h1 << test_stimulus_control[PRTC_F_CH_HI:PRTC_F_CH_LO];
      end
   end
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_phy_reset <= 1'b0;
         o_phy_restart <= 1'b0;
         o_pulse_level_select <= PRTC_PULSE_M2;
         o_channel_enable <= 4'h0;
         o_ten_test_enable <= 1'b0;
         o_ten_pattern <= 4'h0;
      end else begin
         o_phy_reset <= soft_full_reset; // [R1]
         o_phy_restart <= soft_restart_keep_regs; // [R3]
         o_pulse_level_select <= test_stimulus_control[PRTC_F_PULSE_HI:PRTC_F_PULSE_LO]; // [R4]
         o_channel_enable <= next_channel_enable;
         o_ten_test_enable <= test_stimulus_control[PRTC_B_TEN_EN]; // [R13]
         o_ten_pattern <= test_stimulus_control[PRTC_F_PAT_HI:0];
      end
   end
   // ==========================================================
   // Pattern generator; stops while the PHY is held in reset or restart
   prtc_pattern_gen #(
      .CNT_W(5)
   ) u_pattern (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_run(fast_ethernet_pattern_enable && state == PRTC_IDLE), // [R7]
      .i_zero_count(zero_count), // [R5]
      .o_symbol_valid(o_symbol_valid),
      .o_symbol_one(o_symbol_one)
   );
endmodule : prtc_top
